// File: shared/hbc_pkg.sv
// Package for the dual H-bridge host controller
package hbc_pkg;
    // Command modes per bridge
    typedef enum logic [2:0] {
        HBC_COAST = 3'h0,
        HBC_FWD   = 3'h1,
        HBC_REV   = 3'h2,
        HBC_BRAKE = 3'h3
    } hbc_cmd_e;

    // Decay style used while modulating
    typedef enum logic {
        HBC_SLOW = 1'b0,
        HBC_FAST = 1'b1
    } hbc_decay_e;

    // Per-bridge command from the user side
    typedef struct packed {
        hbc_cmd_e   mode;
        hbc_decay_e decay;
        logic       pwm_en;
        logic [7:0] duty;
    } hbc_cmd_s;

    // Pin pair toward one bridge
    typedef struct packed {
        logic in_one;
        logic in_two;
    } hbc_pins_s;

    localparam int    HBC_CLK_HZ       = 20_000_000;
    localparam int    HBC_PWM_MAX_HZ   = 100_000;
    localparam int    HBC_PWM_STEPS    = 256;
    // Step rate so that one full period is never faster than the limit
    localparam int    HBC_STEP_HZ      = HBC_PWM_MAX_HZ * HBC_PWM_STEPS;
    localparam int    HBC_DIV_CYC_RAW  = (HBC_CLK_HZ + HBC_STEP_HZ - 1) / HBC_STEP_HZ;
    localparam int    HBC_DIV_CYC      = (HBC_DIV_CYC_RAW < 1) ? 1 : HBC_DIV_CYC_RAW;
    localparam int    HBC_DIV_W        = 8;
    localparam logic [HBC_DIV_W-1:0] HBC_DIV_LAST = HBC_DIV_W'(HBC_DIV_CYC - 1);
    localparam logic [7:0] HBC_DUTY_RST = 8'h00;
endpackage

// File: rtl/hbc_pwm.sv
// Shared PWM step divider and ramp for both bridges
`timescale 1ns/1ps
module hbc_pwm
    import hbc_pkg::*;
(
    input  wire logic       clk_sys,  // System clock
    input  wire logic       rst,      // Async reset
    output logic [7:0]      ramp_q    // PWM ramp value
);
    logic [HBC_DIV_W-1:0] div_q;
    wire                  step_en = (div_q == HBC_DIV_LAST);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q  <= '0;
            ramp_q <= 8'h00;
        end else begin
            div_q <= step_en ? '0 : div_q + 1'b1;
            if (step_en) begin
                ramp_q <= ramp_q + 8'h01;
            end
        end
    end
endmodule // hbc_pwm

// File: rtl/hbc_ctrl.sv
// Host controller driving the input pins of a dual H-bridge driver
// How it works
// - Host holds inputs steady for full drive or modulates for speed.
// - Modulation never exceeds the supported maximum frequency.
// - Preferred modulation alternates drive with brake.
// - Fast decay modulates one input, other held low.
// - Slow decay holds one input high, modulates the other.
// - Parallel mode ties first inputs together and second inputs together.
`timescale 1ns/1ps
module hbc_ctrl
    import hbc_pkg::*;
(
    input  wire logic     clk_sys,            // System clock, 20 MHz
    input  wire logic     rst,                // Async reset, active high
    input  wire logic     awake_req,          // Request device awake
    input  wire logic     parallel_en,        // Parallel bridge mode
    input  wire hbc_cmd_s cmd_a,              // Bridge A command
    input  wire hbc_cmd_s cmd_b,              // Bridge B command (unused in parallel)
    input  wire logic     fault_indicator_n,  // Device fault pin, async
    output logic          low_power_request_n,// Sleep pin to device
    output logic          bridge_a_input_one, // Bridge A input one
    output logic          bridge_a_input_two, // Bridge A input two
    output logic          bridge_b_input_one, // Bridge B input one
    output logic          bridge_b_input_two, // Bridge B input two
    output logic          fault_q             // Synchronised fault, active high
);
    logic [7:0] ramp;
    logic       flt_s1_q;
    logic       flt_s2_q;

    hbc_pwm u_pwm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ramp_q  (ramp)
    );

    // Map a command plus PWM phase to an input pin pair
    function automatic hbc_pins_s pin_map(input hbc_cmd_s c, input logic [7:0] r);
        logic on;
        hbc_pins_s p;
        on = !c.pwm_en || (r < c.duty);
        p  = '{in_one: 1'b0, in_two: 1'b0};
        unique case (c.mode)
            HBC_FWD: begin
                if (c.decay == HBC_FAST) begin
                    p = '{in_one: on, in_two: 1'b0};
                end else begin
                    p = '{in_one: 1'b1, in_two: !on};
                end
            end
            HBC_REV: begin
                if (c.decay == HBC_FAST) begin
                    p = '{in_one: 1'b0, in_two: on};
                end else begin
                    p = '{in_one: !on, in_two: 1'b1};
                end
            end
            HBC_BRAKE: p = '{in_one: 1'b1, in_two: 1'b1};
            default:   p = '{in_one: 1'b0, in_two: 1'b0};
        endcase
        return p;
    endfunction

    wire hbc_pins_s pins_a = pin_map(cmd_a, ramp);
    // Parallel mode: both bridges carry the same pair, avoiding fighting outputs
    wire hbc_pins_s pins_b = parallel_en ? pins_a : pin_map(cmd_b, ramp);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_power_request_n <= 1'b0;
            bridge_a_input_one  <= 1'b0;
            bridge_a_input_two  <= 1'b0;
            bridge_b_input_one  <= 1'b0;
            bridge_b_input_two  <= 1'b0;
        end else begin
            low_power_request_n <= awake_req;
            // Inputs stay valid even asleep; the device tolerates that
            bridge_a_input_one  <= pins_a.in_one;
            bridge_a_input_two  <= pins_a.in_two;
            bridge_b_input_one  <= pins_b.in_one;
            bridge_b_input_two  <= pins_b.in_two;
        end
    end

    // Fault pin comes from outside: two-stage synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flt_s1_q <= 1'b1;
            flt_s2_q <= 1'b1;
            fault_q  <= 1'b0;
        end else begin
            flt_s1_q <= fault_indicator_n;
            flt_s2_q <= flt_s1_q;
            fault_q  <= !flt_s2_q;
        end
    end

    // Step counter: full PWM period never shorter than the limit
    logic [HBC_DIV_W-1:0] chk_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chk_q <= '0;
        end else begin
            chk_q <= (chk_q == HBC_DIV_LAST) ? '0 : chk_q + 1'b1;
        end
    end

    sequence ramp_wrap_s;
        $changed(ramp) ##0 (ramp == 8'h00);
    endsequence

    sleep_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(awake_req) |=> low_power_request_n)
        else $error("Sleep pin did not follow awake request");
    sleep_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(awake_req) |=> !low_power_request_n)
        else $error("Sleep pin did not drop");
    coast_pins_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_COAST) |=> !bridge_a_input_one && !bridge_a_input_two)
        else $error("Coast not driven as both low");
    fwd_full_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_FWD && !cmd_a.pwm_en)
        |=> bridge_a_input_one && !bridge_a_input_two)
        else $error("Forward pattern wrong");
    rev_full_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_REV && !cmd_a.pwm_en)
        |=> !bridge_a_input_one && bridge_a_input_two)
        else $error("Reverse pattern wrong");
    brake_pins_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_BRAKE) |=> bridge_a_input_one && bridge_a_input_two)
        else $error("Brake not both high");
    fast_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_FWD && cmd_a.decay == HBC_FAST) |=> !bridge_a_input_two)
        else $error("Fast decay other input not low");
    slow_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_REV && cmd_a.decay == HBC_SLOW) |=> bridge_a_input_two)
        else $error("Slow decay held input not high");
    par_match_a: assert property (@(posedge clk_sys) disable iff (rst)
        parallel_en |=> (bridge_b_input_one == bridge_a_input_one)
                     && (bridge_b_input_two == bridge_a_input_two))
        else $error("Parallel bridges differ");
    pwm_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
        ramp_wrap_s |-> (chk_q == '0))
        else $error("PWM step off divider grid");
    fault_sync_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!fault_indicator_n [*3]) |=> fault_q)
        else $error("Fault not reported");

    // Bridge B owns its pins only outside parallel mode
    wire logic b_own = !parallel_en;

    sequence a_coast_s;
        !bridge_a_input_one && !bridge_a_input_two;
    endsequence

    sequence a_brake_s;
        bridge_a_input_one && bridge_a_input_two;
    endsequence

    coast_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        (b_own && cmd_b.mode == HBC_COAST) |=> !bridge_b_input_one && !bridge_b_input_two)
        else $error("Bridge B coast not both low");

    fwd_full_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        (b_own && cmd_b.mode == HBC_FWD && !cmd_b.pwm_en)
        |=> bridge_b_input_one && !bridge_b_input_two)
        else $error("Bridge B forward pattern wrong");

    rev_full_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        (b_own && cmd_b.mode == HBC_REV && !cmd_b.pwm_en)
        |=> !bridge_b_input_one && bridge_b_input_two)
        else $error("Bridge B reverse pattern wrong");

    brake_b_a: assert property (@(posedge clk_sys) disable iff (rst)
        (b_own && cmd_b.mode == HBC_BRAKE) |=> bridge_b_input_one && bridge_b_input_two)
        else $error("Bridge B brake not both high");

    fast_rev_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_REV && cmd_a.decay == HBC_FAST) |=> !bridge_a_input_one)
        else $error("Fast reverse other input not low");

    slow_fwd_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_FWD && cmd_a.decay == HBC_SLOW) |=> bridge_a_input_one)
        else $error("Slow forward held input not high");

    // Off phase of slow decay must be brake, never coast
    slow_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_FWD && cmd_a.decay == HBC_SLOW && cmd_a.pwm_en
         && ramp >= cmd_a.duty) |=> a_brake_s)
        else $error("Slow decay off phase not brake");

    fast_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode == HBC_FWD && cmd_a.decay == HBC_FAST && cmd_a.pwm_en
         && ramp >= cmd_a.duty) |=> a_coast_s)
        else $error("Fast decay off phase not coast");

    // Guarded against the first edge after reset, where pins leave their reset value
    full_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!$past(rst) && !cmd_a.pwm_en && $stable(cmd_a))
        |=> $stable({bridge_a_input_one, bridge_a_input_two}))
        else $error("Full drive pins not steady");

    fault_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (fault_indicator_n [*3]) |=> !fault_q)
        else $error("Fault not cleared");

    sleep_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !awake_req |=> !low_power_request_n)
        else $error("Sleep pin high without request");

    par_brake_a: assert property (@(posedge clk_sys) disable iff (rst)
        (parallel_en && cmd_a.mode == HBC_BRAKE)
        |=> bridge_b_input_one && bridge_b_input_two)
        else $error("Parallel brake not copied");

    // Undefined mode codes fall back to the safe coast state
    mode_bad_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cmd_a.mode > HBC_BRAKE) |=> a_coast_s)
        else $error("Undefined mode not coast");
endmodule // hbc_ctrl

// File: verif/hbc_dev_model.sv
// Behavioural model of one bridge of the driver device
`timescale 1ns/1ps
module hbc_dev_model (
    input  wire logic       sleep_n, // Sleep pin, low = asleep
    input  wire logic       in_one,  // Bridge input one
    input  wire logic       in_two,  // Bridge input two
    output logic [3:0]      outs     // {one_oe_n, one_lvl, two_oe_n, two_lvl}
);
    wire logic drive_w = sleep_n & (in_one | in_two);
    // Zero-delay decode: dead time and deglitch are far below a clock
    // Sense, chopping and wake timing are analog side; the model leaves them out
    assign outs = {~drive_w, drive_w & in_one & ~in_two,
                   ~drive_w, drive_w & in_two & ~in_one};
endmodule // hbc_dev_model

// File: verif/hbc_ctrl_tb.sv
// Self-checking bench for the dual H-bridge host controller
`timescale 1ns/1ps
module hbc_ctrl_tb;
    import hbc_pkg::*;
    logic       clk_sys, rst, awake_req, parallel_en, fault_indicator_n;
    hbc_cmd_s   cmd_a, cmd_b;
    logic       sleep_n, a1, a2, b1, b2, fault_q;
    logic [3:0] outs_a, outs_b;
    int         bad_count, compares, cyc;

    hbc_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .awake_req(awake_req),
        .parallel_en(parallel_en), .cmd_a(cmd_a), .cmd_b(cmd_b),
        .fault_indicator_n(fault_indicator_n), .low_power_request_n(sleep_n),
        .bridge_a_input_one(a1), .bridge_a_input_two(a2),
        .bridge_b_input_one(b1), .bridge_b_input_two(b2), .fault_q(fault_q));
    hbc_dev_model i_dev_a (.sleep_n(sleep_n), .in_one(a1), .in_two(a2), .outs(outs_a));
    hbc_dev_model i_dev_b (.sleep_n(sleep_n), .in_one(b1), .in_two(b2), .outs(outs_b));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Counts: compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic t_sleep();
        cmd_a = '{HBC_FWD, HBC_SLOW, 1'b0, 8'h00};
        cyc_n(2);
        check(sleep_n, 8'h00);
        check(outs_a, 8'h0A);
        awake_req = 1'b1;
        cyc_n(2);
        check(sleep_n, 8'h01);
        check(outs_a, 8'h04);
        $display("Test sleep done");
    endtask

    task automatic t_modes();
        logic [3:0] exp_o [5] = '{4'hA, 4'h4, 4'h1, 4'h0, 4'hA};
        logic [1:0] exp_p [5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00};
        for (int m = 0; m < 5; m++) begin
            cmd_a = '{hbc_cmd_e'(m), HBC_SLOW, 1'b0, 8'h00};
            cmd_b = '{hbc_cmd_e'(4 - m), HBC_FAST, 1'b0, 8'h00};
            cyc_n(2);
            check({a1, a2}, exp_p[m]);
            check(outs_a, exp_o[m]);
            check({b1, b2}, exp_p[4 - m]);
        end
        $display("Test modes done");
    endtask

    task automatic t_pwm();
        int on;
        logic [1:0] drv, idle;
        for (int k = 0; k < 4; k++) begin
            drv = k[1] ? 2'b01 : 2'b10;
            idle = k[0] ? 2'b00 : 2'b11;
            cmd_a = '{k[1] ? HBC_REV : HBC_FWD, hbc_decay_e'(k[0]), 1'b1, 8'h40};
            on = 0;
            cyc_n(2);
            // One full period counted, so on-cycles must equal duty exactly
            repeat (HBC_PWM_STEPS) begin
                if ({a1, a2} === drv) on++;
                else check({a1, a2}, idle);
                cyc_n(1);
            end
            check(on[7:0], 8'h40);
        end
        $display("Test pwm done");
    endtask

    task automatic t_par();
        parallel_en = 1'b1;
        cmd_a = '{HBC_REV, HBC_SLOW, 1'b0, 8'h00};
        cmd_b = '{HBC_FWD, HBC_SLOW, 1'b0, 8'h00};
        cyc_n(2);
        check({b1, b2}, 8'h01);
        check(outs_b, 8'h01);
        parallel_en = 1'b0;
        awake_req = 1'b0;
        cyc_n(2);
        check(sleep_n, 8'h00);
        check(outs_a, 8'h0A);
        awake_req = 1'b1;
        cyc_n(2);
        check(outs_a, 8'h01);
        $display("Test parallel done");
    endtask

    task automatic t_fault();
        fault_indicator_n = 1'b0;
        cyc_n(4);
        check(fault_q, 8'h01);
        fault_indicator_n = 1'b1;
        cyc_n(4);
        check(fault_q, 8'h00);
        $display("Test fault done");
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        awake_req = 1'b0;
        parallel_en = 1'b0;
        fault_indicator_n = 1'b1;
        cmd_a = '0;
        cmd_b = '0;
        cyc_n(4);
        check(sleep_n, 8'h00);
        rst = 1'b0;
        t_sleep();
        t_modes();
        t_pwm();
        t_par();
        t_fault();
        end_sim();
    end
endmodule // hbc_ctrl_tb
